/* verilog/decoder_pkg.sv */
// Constants shared by the memory address decoder
package decoder_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int REG_ADDR_W = 2;
   localparam int REG_DATA_W = 16;
   localparam int SLOT_W = 3;
   localparam int WIN_W = 6;
   localparam int SEL_COUNT = 4;

   // ------------------------------------------------------------
   // Part size codes
   // ------------------------------------------------------------
   localparam logic [1:0] SIZE_1K = 2'h0;
   localparam logic [1:0] SIZE_2K = 2'h1;
   localparam logic [1:0] SIZE_4K = 2'h2;

   // ------------------------------------------------------------
   // Select indices
   // ------------------------------------------------------------
   localparam int SEL_ROM0 = 0;
   localparam int SEL_ROM1 = 1;
   localparam int SEL_ROM2 = 2;
   localparam int SEL_RAM = 3;

   // ------------------------------------------------------------
   // Register indices
   // ------------------------------------------------------------
   localparam logic [REG_ADDR_W-1:0] REG_CONFIG = 2'h0;
   localparam logic [REG_ADDR_W-1:0] REG_SLOTS = 2'h1;
   localparam logic [REG_ADDR_W-1:0] REG_WINDOWS = 2'h2;
   localparam logic [REG_ADDR_W-1:0] REG_STATUS = 2'h3;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CFG_SIZE_LSB = 0;
   localparam int CFG_BASE_LSB = 2;
   localparam int WIN0_LSB = 0;
   localparam int WIN0_EN_BIT = 6;
   localparam int WIN1_LSB = 8;
   localparam int WIN1_EN_BIT = 14;
   localparam int STAT_DIS_BIT = 4;
   localparam int STAT_POP_BIT = 5;

   // ------------------------------------------------------------
   // Reset values: 1K parts, block E000, RAM at FC00, gap at E800
   // ------------------------------------------------------------
   localparam logic [1:0] RST_SIZE = SIZE_1K;
   localparam logic [2:0] RST_BASE = 3'h7;
   localparam logic [2:0] RST_SLOT_ROM0 = 3'h0;
   localparam logic [2:0] RST_SLOT_ROM1 = 3'h1;
   localparam logic [2:0] RST_SLOT_ROM2 = 3'h3;
   localparam logic [2:0] RST_SLOT_RAM = 3'h7;
   localparam logic [5:0] RST_WIN = 6'h00;

endpackage

/* verilog/slot_match.sv */
// One strapped slot comparator inside the chosen base block
module slot_match (
   // Address and settings
   input wire logic [decoder_pkg::ADDR_W-1:0] addr_in,
   input wire logic [1:0] size_in,
   input wire logic [2:0] base_in,
   input wire logic [decoder_pkg::SLOT_W-1:0] slot_in,
   // Result
   output logic hit_out
);
   import decoder_pkg::*;

   // ------------------------------------------------------------
   // Block and slot compare per part size
   // ------------------------------------------------------------
   wire logic in_block_1k;
   wire logic in_block_2k;
   wire logic in_block_4k;
   wire logic hit_1k;
   wire logic hit_2k;
   wire logic hit_4k;

   assign in_block_1k = (addr_in[15:13] == base_in);
   assign in_block_2k = (addr_in[15:14] == base_in[1:0]);
   assign in_block_4k = (addr_in[15] == base_in[0]);
   assign hit_1k = in_block_1k && (addr_in[12:10] == slot_in);
   assign hit_2k = in_block_2k && (addr_in[13:11] == slot_in);
   assign hit_4k = in_block_4k && (addr_in[14:12] == slot_in);

   // Unused size code selects nothing
   assign hit_out = (size_in == SIZE_1K) ? hit_1k :
                    (size_in == SIZE_2K) ? hit_2k :
                    (size_in == SIZE_4K) ? hit_4k : 1'b0;
endmodule

/* verilog/mem_decoder.sv */
// Memory address decoder with chip selects for three ROM sockets and a RAM pair
//
// Overview of operation
// - Three part sizes give 3K to 12K
// - Default ROM at E000, RAM at FC00
// - Default straps leave E800-EBFF unselected
// - 1K parts: base picks one 8K block
// - 1K parts: strapped 1K slot selects socket
// - 2K parts: base picks one 16K block
// - 2K parts: strapped 2K slot selects socket
// - Four independent selects with own slots
// - 2K RAM slot: only lower 1K populated
// - Up to two disable windows silence board
// - Disable window width equals slot size
// - 4K parts: base picks 32K half, 4K slots
// - 4K RAM slot: only first 1K populated
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
module mem_decoder (
   // Clock and reset
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // Processor memory cycle
   input wire logic [decoder_pkg::ADDR_W-1:0] mem_addr_in,
   input wire logic mem_cycle_in,
   // Register port
   input wire logic [decoder_pkg::REG_ADDR_W-1:0] reg_addr_in,
   input wire logic [decoder_pkg::REG_DATA_W-1:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [decoder_pkg::REG_DATA_W-1:0] reg_rdata_out,
   // Chip selects
   output logic rom_socket_zero_sel_out,
   output logic rom_socket_one_sel_out,
   output logic rom_socket_two_sel_out,
   output logic ram_pair_sel_out,
   output logic ram_pair_populated_out,
   output logic board_respond_out
);
   import decoder_pkg::*;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [1:0] part_size;
   logic [2:0] base_block;
   logic [SLOT_W-1:0] slot_strap [SEL_COUNT];
   logic [WIN_W-1:0] win_slot [2];
   logic [1:0] win_enable;
   logic [SEL_COUNT-1:0] last_sel;
   logic last_disabled;
   logic last_populated;

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   wire logic wr_config;
   wire logic wr_slots;
   wire logic wr_windows;

   assign wr_config = reg_write_in && (reg_addr_in == REG_CONFIG);
   assign wr_slots = reg_write_in && (reg_addr_in == REG_SLOTS);
   assign wr_windows = reg_write_in && (reg_addr_in == REG_WINDOWS);

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         part_size <= RST_SIZE;
         base_block <= RST_BASE;
      end else if (wr_config) begin
         part_size <= reg_wdata_in[CFG_SIZE_LSB +: 2];
         base_block <= reg_wdata_in[CFG_BASE_LSB +: 3];
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         slot_strap[SEL_ROM0] <= RST_SLOT_ROM0;
         slot_strap[SEL_ROM1] <= RST_SLOT_ROM1;
         slot_strap[SEL_ROM2] <= RST_SLOT_ROM2;
         slot_strap[SEL_RAM] <= RST_SLOT_RAM;
      end else if (wr_slots) begin
         for (int i = 0; i < SEL_COUNT; i++) begin
            slot_strap[i] <= reg_wdata_in[i*SLOT_W +: SLOT_W];
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         win_slot[0] <= RST_WIN;
         win_slot[1] <= RST_WIN;
         win_enable <= 2'h0;
      end else if (wr_windows) begin
         win_slot[0] <= reg_wdata_in[WIN0_LSB +: WIN_W];
         win_slot[1] <= reg_wdata_in[WIN1_LSB +: WIN_W];
         win_enable <= {reg_wdata_in[WIN1_EN_BIT], reg_wdata_in[WIN0_EN_BIT]};
      end
   end

   // ------------------------------------------------------------
   // Slot comparators, one per select
   // ------------------------------------------------------------
   logic [SEL_COUNT-1:0] slot_hit;

   generate
      for (genvar g = 0; g < SEL_COUNT; g++) begin : gen_sel
         slot_match u_match (
            .addr_in(mem_addr_in),
            .size_in(part_size),
            .base_in(base_block),
            .slot_in(slot_strap[g]),
            .hit_out(slot_hit[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Disable windows, one slot wide in absolute slot units
   // ------------------------------------------------------------
   logic [1:0] win_hit;

   generate
      for (genvar w = 0; w < 2; w++) begin : gen_win
         wire logic m1k;
         wire logic m2k;
         wire logic m4k;
         assign m1k = (mem_addr_in[15:10] == win_slot[w]);
         assign m2k = (mem_addr_in[15:11] == win_slot[w][4:0]);
         assign m4k = (mem_addr_in[15:12] == win_slot[w][3:0]);
         assign win_hit[w] = win_enable[w] && ((part_size == SIZE_1K) ? m1k :
                             (part_size == SIZE_2K) ? m2k :
                             (part_size == SIZE_4K) ? m4k : 1'b0);
      end
   endgenerate

   wire logic disabled;
   wire logic [SEL_COUNT-1:0] sel;
   wire logic ram_low;

   assign disabled = |win_hit;
   assign sel = (mem_cycle_in && !disabled) ? slot_hit : '0;

   // RAM holds data only in the first 1K of its slot
   assign ram_low = (part_size == SIZE_1K) ? 1'b1 :
                    (part_size == SIZE_2K) ? (mem_addr_in[10] == 1'b0) :
                    (mem_addr_in[11:10] == 2'h0);

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rom_socket_zero_sel_out = sel[SEL_ROM0];
   assign rom_socket_one_sel_out = sel[SEL_ROM1];
   assign rom_socket_two_sel_out = sel[SEL_ROM2];
   assign ram_pair_sel_out = sel[SEL_RAM];
   assign ram_pair_populated_out = sel[SEL_RAM] && ram_low;
   assign board_respond_out = |sel;

   // ------------------------------------------------------------
   // Status capture of the last memory cycle
   // ------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         last_sel <= '0;
         last_disabled <= 1'b0;
         last_populated <= 1'b0;
      end else if (mem_cycle_in) begin
         last_sel <= sel;
         last_disabled <= disabled;
         last_populated <= sel[SEL_RAM] && ram_low;
      end
   end

   // ------------------------------------------------------------
   // Read path, data one cycle after the strobe
   // ------------------------------------------------------------
   logic [REG_DATA_W-1:0] read_mux;

   always_comb begin
      read_mux = '0;
      case (reg_addr_in)
         REG_CONFIG: begin
            read_mux[CFG_SIZE_LSB +: 2] = part_size;
            read_mux[CFG_BASE_LSB +: 3] = base_block;
         end
         REG_SLOTS: begin
            for (int i = 0; i < SEL_COUNT; i++) begin
               read_mux[i*SLOT_W +: SLOT_W] = slot_strap[i];
            end
         end
         REG_WINDOWS: begin
            read_mux[WIN0_LSB +: WIN_W] = win_slot[0];
            read_mux[WIN1_LSB +: WIN_W] = win_slot[1];
            read_mux[WIN0_EN_BIT] = win_enable[0];
            read_mux[WIN1_EN_BIT] = win_enable[1];
         end
         REG_STATUS: begin
            read_mux[SEL_COUNT-1:0] = last_sel;
            read_mux[STAT_DIS_BIT] = last_disabled;
            read_mux[STAT_POP_BIT] = last_populated;
         end
         default: begin
            read_mux = '0;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= '0;
      end else if (reg_read_in) begin
         reg_rdata_out <= read_mux;
      end else begin
         reg_rdata_out <= '0;
      end
   end
endmodule

/* sim/mem_decoder_assertions.sv */
// Concurrent checks on the memory decoder ports
module mem_decoder_assertions (
   // Inputs
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [15:0] mem_addr_in,
   input wire logic mem_cycle_in,
   input wire logic [1:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   // Outputs
   input wire logic [15:0] reg_rdata_out,
   input wire logic rom_socket_zero_sel_out,
   input wire logic rom_socket_one_sel_out,
   input wire logic rom_socket_two_sel_out,
   input wire logic ram_pair_sel_out,
   input wire logic ram_pair_populated_out,
   input wire logic board_respond_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);
   // ------------------------------------------------------------
   // Helpers: default straps stay until the first settings write
   // ------------------------------------------------------------
   logic dirty;
   wire [3:0] sels = {ram_pair_sel_out, rom_socket_two_sel_out,
      rom_socket_one_sel_out, rom_socket_zero_sel_out};
   wire [5:0] page = mem_addr_in[15:10];
   wire fresh = !dirty && mem_cycle_in;
   always_ff @(posedge clock_in) begin
      dirty <= !sys_rst_in && (dirty || (reg_write_in && reg_addr_in != 2'h3));
   end
   sequence s_wr_rd;
      reg_write_in && reg_addr_in == 2'h1 ##1 !reg_write_in ##1
         reg_read_in && reg_addr_in == 2'h1;
   endsequence
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_quiet; !mem_cycle_in |-> sels == 4'h0 && !board_respond_out; endproperty
   property p_or; board_respond_out == (sels != 4'h0); endproperty
   property p_pop; ram_pair_populated_out |-> ram_pair_sel_out && board_respond_out; endproperty
   property p_ram; fresh && page == 6'h3F |-> sels == 4'h8 && ram_pair_populated_out; endproperty
   property p_gap; fresh && page == 6'h3A |-> !board_respond_out; endproperty
   property p_rom0; fresh && page == 6'h38 |-> sels == 4'h1; endproperty
   property p_rom2; fresh && page == 6'h3B |-> sels == 4'h4; endproperty
   property p_outside; fresh && page < 6'h38 |-> sels == 4'h0; endproperty
   property p_back;
      s_wr_rd |=> reg_rdata_out == ($past(reg_wdata_in, 3) & 16'h0FFF);
   endproperty
   a_quiet: assert property (p_quiet) else $error("select outside a cycle");
   a_or: assert property (p_or) else $error("respond differs from selects");
   a_pop: assert property (p_pop) else $error("populated without ram");
   a_ram: assert property (p_ram) else $error("default ram missing");
   a_gap: assert property (p_gap) else $error("default gap answered");
   a_rom0: assert property (p_rom0) else $error("default rom zero missing");
   a_rom2: assert property (p_rom2) else $error("default rom two missing");
   a_outside: assert property (p_outside) else $error("select outside block");
   a_back: assert property (p_back) else $error("slot readback wrong");
endmodule

bind mem_decoder mem_decoder_assertions u_chk (.clock_in, .sys_rst_in, .mem_addr_in,
   .mem_cycle_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
   .rom_socket_zero_sel_out, .rom_socket_one_sel_out, .rom_socket_two_sel_out,
   .ram_pair_sel_out, .ram_pair_populated_out, .board_respond_out);

/* sim/cpu_bus_model.sv */
// Processor model issuing memory cycles toward the decoder
module cpu_bus_model (
   // Clock and request
   input wire logic clock_in,
   input wire logic [15:0] req_addr_in,
   input wire logic req_go_in,
   // Bus toward the decoder
   output logic [15:0] mem_addr_out,
   output logic mem_cycle_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      mem_addr_out = 16'h0000;
      mem_cycle_out = 1'b0;
   end
   // Between cycles the released address shows the inverse of the last
   always @(posedge clock_in) begin
      mem_cycle_out <= req_go_in;
      mem_addr_out <= req_go_in ? req_addr_in : ~mem_addr_out;
   end
endmodule

/* sim/mem_decoder_tb_top.sv */
// Self-checking bench for the memory address decoder
module mem_decoder_tb_top;
   import decoder_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in, sys_rst_in, reg_write_in, reg_read_in, req_go;
   logic [1:0] reg_addr_in;
   logic [15:0] reg_wdata_in, req_addr, cfg, slt, win, v, stat;
   wire [15:0] mem_addr_in, reg_rdata_out;
   wire mem_cycle_in, rom_socket_zero_sel_out, rom_socket_one_sel_out, rom_socket_two_sel_out;
   wire ram_pair_sel_out, ram_pair_populated_out, board_respond_out;
   wire [5:0] got = {board_respond_out, ram_pair_populated_out, ram_pair_sel_out,
      rom_socket_two_sel_out, rom_socket_one_sel_out, rom_socket_zero_sel_out};
   int error_cnt = 0, compares = 0, seed = 46, cycles = 0, t, s, b, z;
   cpu_bus_model u_cpu (.clock_in, .req_addr_in(req_addr), .req_go_in(req_go),
      .mem_addr_out(mem_addr_in), .mem_cycle_out(mem_cycle_in));
   mem_decoder u_dut (.clock_in, .sys_rst_in, .mem_addr_in, .mem_cycle_in, .reg_addr_in,
      .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .rom_socket_zero_sel_out,
      .rom_socket_one_sel_out, .rom_socket_two_sel_out, .ram_pair_sel_out,
      .ram_pair_populated_out, .board_respond_out);
   // ------------------------------------------------------------
   // Helpers and reference model
   // ------------------------------------------------------------
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int ref_dec(int a);
      int sz, u, r, i, d;
      sz = cfg & 3;
      u = a >> (10 + sz);
      r = 0;
      d = 0;
      if (sz == 3) return 0;
      // Bit 6 marks a disable window hit, anywhere in memory
      for (i = 0; i < 2; i++)
         if (((win >> (8 * i + 6)) & 1) && u == ((win >> (8 * i)) & (63 >> sz))) d = 64;
      if (d != 0 || (a >> (13 + sz)) != ((cfg >> 2) & (7 >> sz))) return d;
      for (i = 0; i < 4; i++)
         if ((u & 7) == ((slt >> (3 * i)) & 7)) r |= 1 << i;
      if (r >= 8 && ((a >> 10) & ((1 << sz) - 1)) == 0) r |= 16;
      if (r != 0) r |= 32;
      return r;
   endfunction
   function automatic int ref_stat(int a);
      int r;
      r = ref_dec(a);
      return (r & 15) | (((r >> 6) & 1) << 4) | (((r >> 4) & 1) << 5);
   endfunction
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("Mismatches %0d, compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(logic [1:0] a, logic [15:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge clock_in);
      reg_write_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic rd(logic [1:0] a, logic [15:0] e);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge clock_in);
      reg_read_in <= 1'b0;
      @(negedge clock_in);
      check(reg_rdata_out, e);
      @(posedge clock_in);
   endtask
   task automatic sweep(int n);
      int i;
      for (i = 0; i < n; i++) begin
         req_addr <= 16'(((i % 64) << 10) | (rnd() & 16'h03FF));
         req_go <= (rnd() & 3) != 0;
         @(posedge clock_in);
      end
   endtask
   // ------------------------------------------------------------
   // Clock, shadow settings, decode compare and timeout
   // ------------------------------------------------------------
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cycles++;
      if (cycles > 8000) begin
         error_cnt++;
         tally_and_finish();
      end
      if (sys_rst_in) begin
         cfg <= 16'h001C;
         slt <= 16'h0EC8;
         win <= 16'h0000;
         stat <= 16'h0000;
      end else if (reg_write_in) begin
         if (reg_addr_in == REG_CONFIG) cfg <= reg_wdata_in;
         if (reg_addr_in == REG_SLOTS) slt <= reg_wdata_in;
         if (reg_addr_in == REG_WINDOWS) win <= reg_wdata_in;
      end
      if (!sys_rst_in && mem_cycle_in) stat <= 16'(ref_stat(mem_addr_in));
   end
   always @(negedge clock_in) begin
      if (!sys_rst_in && cycles > 2) begin
         check(16'(got), 16'(mem_cycle_in ? ref_dec(mem_addr_in) & 63 : 0));
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      sys_rst_in = 1'b1;
      reg_write_in = 1'b0;
      reg_read_in = 1'b0;
      reg_addr_in = 2'h0;
      reg_wdata_in = 16'h0000;
      req_addr = 16'hFC10;
      req_go = 1'b1;
      for (t = 0; t < 18; t++) begin
         repeat (2) @(posedge clock_in);
         sys_rst_in <= 1'b0;
         rd(REG_CONFIG, 16'h001C);
         rd(REG_SLOTS, 16'h0EC8);
         rd(REG_WINDOWS, 16'h0000);
         sweep(64);
         s = rnd() & 7;
         b = rnd() & 7;
         z = t & 3;
         v = 16'(s | ((s + 1) & 7) << 3 | ((s + 3) & 7) << 6 | ((s + 7) & 7) << 9);
         wr(REG_CONFIG, 16'(z | b << 2));
         wr(REG_SLOTS, v);
         rd(REG_SLOTS, v);
         wr(REG_WINDOWS, 16'((((b & (7 >> z)) << 3) | ((s + 1) & 7)) | (rnd() & 16'h7F40)));
         wr(REG_STATUS, 16'hFFFF);
         rd(REG_CONFIG, 16'(z | b << 2));
         sweep(96);
         req_go <= 1'b0;
         repeat (2) @(posedge clock_in);
         rd(REG_STATUS, stat);
         sys_rst_in <= 1'b1;
      end
      tally_and_finish();
   end
endmodule
